/* sense_regs_pkg.sv */
package sense_regs_pkg;

	// Byte offsets of the register words
	localparam logic [11:0] MODCFG_OFFSET   = 12'h044;
	localparam logic [11:0] ANACTRL_OFFSET  = 12'h048;
	localparam logic [11:0] IFLAGS_OFFSET   = 12'h054;
	localparam logic [11:0] IFSET_OFFSET    = 12'h058;
	localparam logic [11:0] IFCLR_OFFSET    = 12'h05C;
	localparam logic [11:0] IENABLE_OFFSET  = 12'h060;

	// Modulator configuration fields
	localparam int STEP_DIS_POS  = 28;
	localparam int RES_LSB       = 20;
	localparam int RATE_LSB      = 16;
	localparam int INTERVAL_LSB  = 8;
	localparam int STEP_LSB      = 0;
	localparam logic [31:0] MODCFG_MASK  = 32'h103F0FFF;
	localparam logic [31:0] MODCFG_RESET = 32'h00000000;

	// Analog control fields
	localparam int DISCHARGE_LSB = 20;
	localparam int SCALE_LSB     = 8;
	localparam int REFLEVEL_LSB  = 4;
	localparam logic [31:0] ANACTRL_MASK  = 32'h00700770;
	localparam logic [31:0] ANACTRL_RESET = 32'h00000070;

	// Interrupt flag positions
	localparam int NUM_FLAGS             = 5;
	localparam int FLAG_COMPARATOR_EVENT = 0;
	localparam int FLAG_RESULT_READY     = 1;
	localparam int FLAG_END_OF_SCAN      = 2;
	localparam int FLAG_TRANSFER_OVERFLOW = 3;
	localparam int FLAG_ANALOG_BUS_CONFLICT = 4;
	localparam logic [4:0] FLAGS_RESET  = 5'h00;
	localparam logic [4:0] ENABLE_RESET = 5'h00;

	// Resolution selections and their widths
	typedef enum logic [1:0] {
		resolution_10bit,
		resolution_12bit,
		resolution_14bit,
		resolution_16bit
	} resolution_t;
	localparam logic [4:0] BITS_10 = 5'h0A;
	localparam logic [4:0] BITS_12 = 5'h0C;
	localparam logic [4:0] BITS_14 = 5'h0E;
	localparam logic [4:0] BITS_16 = 5'h10;

	// Interval field value 0 stands for this many tests
	localparam logic [6:0] INTERVAL_ZERO_TESTS = 7'h40;
	localparam logic [6:0] TEST_COUNT_RESET    = 7'h00;
	localparam logic [7:0] STEP_MIN            = 8'h01;

endpackage

/* sense_step_control.sv */
`timescale 1ns/1ps
`default_nettype none
module sense_step_control
	import sense_regs_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       load_in,
	input  wire logic       test_in,
	input  wire logic [7:0] initial_step_size_in,
	input  wire logic [3:0] step_halving_interval_in,
	input  wire logic       step_reduction_disable_in,
	output var  logic [7:0] step_out
);

	logic [6:0] test_count;
	wire  [6:0] interval_tests;
	wire        interval_done;
	wire        reduce;
	wire  [7:0] halved_step;

	assign interval_tests = (step_halving_interval_in == 4'h0) ?
		INTERVAL_ZERO_TESTS : {3'h0, step_halving_interval_in};
	assign interval_done  = test_in && (test_count + 7'h01 >= interval_tests);
	// Halving never leaves the step below one code, so the loop keeps tracking
	assign reduce         = interval_done && !step_reduction_disable_in;
	assign halved_step    = (step_out > STEP_MIN) ? (step_out >> 1) : STEP_MIN;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			test_count <= TEST_COUNT_RESET;
			step_out   <= 8'h00;
		end else if (load_in) begin
			test_count <= TEST_COUNT_RESET;
			step_out   <= initial_step_size_in;
		end else if (test_in) begin
			test_count <= interval_done ? TEST_COUNT_RESET : test_count + 7'h01;
			if (reduce) begin
				step_out <= halved_step;
			end
		end
	end

endmodule
`default_nettype wire

/* sense_dm_config_and_irq_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module sense_dm_config_and_irq_flags
	import sense_regs_pkg::*;
(
	input  wire logic        MCLK_IN,
	input  wire logic        RESET_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	input  wire logic [3:0]  PSTRB_IN,
	output var  logic [31:0] PRDATA_OUT,
	output var  logic        PREADY_OUT,
	output var  logic        PSLVERR_OUT,
	input  wire logic        READ_CLEAR_ENABLE_IN,
	input  wire logic        BUS_CONFLICT_IN,
	input  wire logic        CONVERSION_START_IN,
	input  wire logic        COMPARISON_TEST_IN,
	input  wire logic        CONVERSION_DONE_IN,
	input  wire logic [15:0] CONVERSION_RESULT_IN,
	input  wire logic        SCAN_DONE_IN,
	input  wire logic        TRANSFER_REQUEST_ENABLE_IN,
	input  wire logic        TRANSFER_READ_IN,
	input  wire logic        COMPARE_ENABLE_IN,
	input  wire logic        AVERAGE_WINDOW_ENABLE_IN,
	input  wire logic        WINDOW_MATCH_IN,
	input  wire logic        COMPARE_POLARITY_IN,
	input  wire logic [15:0] COMPARE_THRESHOLD_IN,
	output var  logic [31:0] MODULATOR_CONFIG_OUT,
	output var  logic [31:0] ANALOG_CONTROL_OUT,
	output var  logic [4:0]  RESULT_BITS_OUT,
	output var  logic [7:0]  MODULATOR_STEP_OUT,
	output var  logic        IRQ_OUT
);

	logic [31:0] modulator_configuration;
	logic [31:0] analog_current_control;
	logic [4:0]  interrupt_flags;
	logic [4:0]  interrupt_enable;
	logic [4:0]  returned_flags;
	logic        result_unread;

	wire        setup_phase;
	wire        access_done;
	wire        wr_done;
	wire        rd_done;
	wire        hit_modcfg;
	wire        hit_anactrl;
	wire        hit_iflags;
	wire        hit_ifset;
	wire        hit_ifclr;
	wire        hit_ienable;
	wire        mapped;
	wire [31:0] strobe_mask;
	wire [31:0] masked_wdata;
	wire [31:0] read_mux;
	wire [4:0]  hw_events;
	wire [4:0]  sw_set;
	wire [4:0]  sw_clear;
	wire [4:0]  next_flags;
	wire        threshold_met;
	wire        comparator_hit;
	wire        overflow_hit;
	wire        next_unread;
	wire [31:0] next_modcfg;
	wire [31:0] next_anactrl;
	wire [4:0]  next_enable;
	wire [1:0]  resolution_field;

	// Answer comes on the second access cycle, so read data is stable
	assign setup_phase  = PSEL_IN && PENABLE_IN && !PREADY_OUT;
	assign access_done  = PSEL_IN && PENABLE_IN && PREADY_OUT;
	assign wr_done      = access_done && PWRITE_IN;
	assign rd_done      = access_done && !PWRITE_IN;

	assign hit_modcfg   = (PADDR_IN == MODCFG_OFFSET);
	assign hit_anactrl  = (PADDR_IN == ANACTRL_OFFSET);
	assign hit_iflags   = (PADDR_IN == IFLAGS_OFFSET);
	assign hit_ifset    = (PADDR_IN == IFSET_OFFSET);
	assign hit_ifclr    = (PADDR_IN == IFCLR_OFFSET);
	assign hit_ienable  = (PADDR_IN == IENABLE_OFFSET);
	assign mapped       = hit_modcfg || hit_anactrl || hit_iflags ||
		hit_ifset || hit_ifclr || hit_ienable;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign strobe_mask[8*g+7:8*g] = {8{PSTRB_IN[g]}};
		end
	endgenerate
	assign masked_wdata = PWDATA_IN & strobe_mask;

	// Reserved bits are not stored; software keeps them zero
	assign next_modcfg  = (modulator_configuration & ~strobe_mask) |
		(masked_wdata & MODCFG_MASK);
	assign next_anactrl = (analog_current_control & ~strobe_mask) |
		(masked_wdata & ANACTRL_MASK);
	assign next_enable  = PSTRB_IN[0] ? PWDATA_IN[4:0] : interrupt_enable;

	// Set register reads as zero; its read value has no meaning
	assign read_mux =
		hit_modcfg  ? modulator_configuration :
		hit_anactrl ? analog_current_control :
		(hit_iflags || hit_ifclr) ? {27'h0, interrupt_flags} :
		hit_ienable ? {27'h0, interrupt_enable} : 32'h00000000;

	assign threshold_met  = COMPARE_POLARITY_IN ?
		(CONVERSION_RESULT_IN > COMPARE_THRESHOLD_IN) :
		(CONVERSION_RESULT_IN <= COMPARE_THRESHOLD_IN);
	assign comparator_hit = COMPARE_ENABLE_IN && (AVERAGE_WINDOW_ENABLE_IN ?
		WINDOW_MATCH_IN :
		(CONVERSION_DONE_IN && threshold_met));
	assign overflow_hit   = TRANSFER_REQUEST_ENABLE_IN && CONVERSION_DONE_IN &&
		result_unread && !TRANSFER_READ_IN;
	assign next_unread    = CONVERSION_DONE_IN ? 1'b1 :
		(TRANSFER_READ_IN ? 1'b0 : result_unread);

	assign hw_events[FLAG_COMPARATOR_EVENT]    = comparator_hit;
	assign hw_events[FLAG_RESULT_READY]        = CONVERSION_DONE_IN;
	assign hw_events[FLAG_END_OF_SCAN]         = SCAN_DONE_IN;
	assign hw_events[FLAG_TRANSFER_OVERFLOW]   = overflow_hit;
	assign hw_events[FLAG_ANALOG_BUS_CONFLICT] = BUS_CONFLICT_IN;

	assign sw_set   = (wr_done && hit_ifset && PSTRB_IN[0]) ?
		PWDATA_IN[4:0] : 5'h00;
	// Read-clear only drops what the read actually returned
	assign sw_clear = ((wr_done && hit_ifclr && PSTRB_IN[0]) ?
		PWDATA_IN[4:0] : 5'h00) |
		((rd_done && hit_ifclr && READ_CLEAR_ENABLE_IN) ?
		returned_flags : 5'h00);
	assign next_flags = (interrupt_flags & ~sw_clear) | sw_set |
		hw_events;

	assign resolution_field = modulator_configuration[RES_LSB+1:RES_LSB];

	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			PREADY_OUT     <= 1'b0;
			PSLVERR_OUT    <= 1'b0;
			PRDATA_OUT     <= 32'h00000000;
			returned_flags <= FLAGS_RESET;
		end else begin
			PREADY_OUT  <= setup_phase;
			PSLVERR_OUT <= setup_phase && !mapped;
			if (setup_phase && !PWRITE_IN) begin
				PRDATA_OUT     <= read_mux;
				returned_flags <= interrupt_flags;
			end
		end
	end

	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			modulator_configuration <= MODCFG_RESET;
			analog_current_control  <= ANACTRL_RESET;
			interrupt_enable        <= ENABLE_RESET;
		end else if (wr_done) begin
			if (hit_modcfg) begin
				modulator_configuration <= next_modcfg;
			end
			if (hit_anactrl) begin
				analog_current_control <= next_anactrl;
			end
			if (hit_ienable) begin
				interrupt_enable <= next_enable;
			end
		end
	end

	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			interrupt_flags <= FLAGS_RESET;
			result_unread   <= 1'b0;
			IRQ_OUT         <= 1'b0;
		end else begin
			interrupt_flags <= next_flags;
			result_unread   <= next_unread;
			IRQ_OUT         <= |(next_flags & interrupt_enable);
		end
	end

	always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			MODULATOR_CONFIG_OUT <= MODCFG_RESET;
			ANALOG_CONTROL_OUT   <= ANACTRL_RESET;
			RESULT_BITS_OUT      <= BITS_10;
		end else begin
			MODULATOR_CONFIG_OUT <= modulator_configuration;
			ANALOG_CONTROL_OUT   <= analog_current_control;
			case (resolution_t'(resolution_field))
				resolution_10bit: RESULT_BITS_OUT <= BITS_10;
				resolution_12bit: RESULT_BITS_OUT <= BITS_12;
				resolution_14bit: RESULT_BITS_OUT <= BITS_14;
				resolution_16bit: RESULT_BITS_OUT <= BITS_16;
				default:          RESULT_BITS_OUT <= BITS_10;
			endcase
		end
	end

	sense_step_control u_step (
		.clk_in                    (MCLK_IN),
		.reset_in                  (RESET_IN),
		.load_in                   (CONVERSION_START_IN),
		.test_in                   (COMPARISON_TEST_IN),
		.initial_step_size_in      (modulator_configuration[STEP_LSB+7:STEP_LSB]),
		.step_halving_interval_in  (modulator_configuration[INTERVAL_LSB+3:INTERVAL_LSB]),
		.step_reduction_disable_in (modulator_configuration[STEP_DIS_POS]),
		.step_out                  (MODULATOR_STEP_OUT)
	);

endmodule
`default_nettype wire

/* sense_irq_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sense_irq_asserts
	import sense_regs_pkg::*;
(
	input  wire logic        MCLK_IN,
	input  wire logic        RESET_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PRDATA_OUT,
	input  wire logic        PREADY_OUT,
	input  wire logic        PSLVERR_OUT,
	input  wire logic        BUS_CONFLICT_IN,
	input  wire logic        CONVERSION_START_IN,
	input  wire logic        COMPARISON_TEST_IN,
	input  wire logic        CONVERSION_DONE_IN,
	input  wire logic        SCAN_DONE_IN,
	input  wire logic        WINDOW_MATCH_IN,
	input  wire logic [31:0] MODULATOR_CONFIG_OUT,
	input  wire logic [4:0]  RESULT_BITS_OUT,
	input  wire logic [7:0]  MODULATOR_STEP_OUT,
	input  wire logic        IRQ_OUT
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (RESET_IN);
	wire mapped = PADDR_IN inside {MODCFG_OFFSET, ANACTRL_OFFSET, IFLAGS_OFFSET,
		IFSET_OFFSET, IFCLR_OFFSET, IENABLE_OFFSET};
	wire event_any = BUS_CONFLICT_IN | CONVERSION_DONE_IN | SCAN_DONE_IN
		| WINDOW_MATCH_IN;
	wire wr_done = PREADY_OUT & PWRITE_IN;
	wire bus_act = PSEL_IN & PENABLE_IN;
	wire [7:0] init_step = MODULATOR_CONFIG_OUT[7:0];

	chk_ready_wait: assert property (PSEL_IN && !PENABLE_IN |=> !PREADY_OUT ##1 PREADY_OUT)
		else $error("ready not after one wait state");
	chk_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready longer than one cycle");
	chk_err_unmapped: assert property (PREADY_OUT |-> PSLVERR_OUT == !mapped)
		else $error("error response does not match decode");
	chk_err_rdata: assert property (PSLVERR_OUT && !PWRITE_IN |-> PRDATA_OUT == 32'h0)
		else $error("unmapped read returned data");
	chk_res_bits: assert property ($stable(MODULATOR_CONFIG_OUT)[*2] |->
		RESULT_BITS_OUT == 5'h0A + {2'h0, MODULATOR_CONFIG_OUT[21:20], 1'h0})
		else $error("result width does not follow field");
	chk_irq_cause: assert property ($rose(IRQ_OUT) |->
		$past(event_any || wr_done) || $past(event_any || wr_done, 2))
		else $error("interrupt rose without cause");
	chk_irq_clear: assert property ($fell(IRQ_OUT) |->
		$past(bus_act) || $past(bus_act, 2))
		else $error("interrupt fell without bus access");
	chk_step_load: assert property (CONVERSION_START_IN && !$past(PREADY_OUT) |=>
		MODULATOR_STEP_OUT == $past(init_step))
		else $error("step not loaded from field");
	chk_step_hold: assert property (MODULATOR_CONFIG_OUT[STEP_DIS_POS] &&
		!CONVERSION_START_IN && !$past(PREADY_OUT) |=> $stable(MODULATOR_STEP_OUT))
		else $error("step changed while reduction disabled");

	cover property (PSLVERR_OUT);
	cover property ($rose(IRQ_OUT));
	cover property (COMPARISON_TEST_IN && MODULATOR_CONFIG_OUT[STEP_DIS_POS]);
endmodule

bind sense_dm_config_and_irq_flags sense_irq_asserts u_chk(.MCLK_IN(MCLK_IN),
	.RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
	.PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
	.BUS_CONFLICT_IN(BUS_CONFLICT_IN), .CONVERSION_START_IN(CONVERSION_START_IN),
	.COMPARISON_TEST_IN(COMPARISON_TEST_IN), .SCAN_DONE_IN(SCAN_DONE_IN),
	.CONVERSION_DONE_IN(CONVERSION_DONE_IN), .WINDOW_MATCH_IN(WINDOW_MATCH_IN),
	.MODULATOR_CONFIG_OUT(MODULATOR_CONFIG_OUT), .IRQ_OUT(IRQ_OUT),
	.RESULT_BITS_OUT(RESULT_BITS_OUT), .MODULATOR_STEP_OUT(MODULATOR_STEP_OUT));
`default_nettype wire

/* sense_dm_config_and_irq_flags_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sense_dm_config_and_irq_flags_tb_top;
	import sense_regs_pkg::*;
	logic MCLK_IN = 1'h0, RESET_IN = 1'h1, PSEL_IN = 1'h0, PENABLE_IN = 1'h0;
	logic PWRITE_IN = 1'h0, READ_CLEAR_ENABLE_IN = 1'h0, COMPARE_POLARITY_IN = 1'h0;
	logic TRANSFER_REQUEST_ENABLE_IN = 1'h0, COMPARE_ENABLE_IN = 1'h1;
	logic AVERAGE_WINDOW_ENABLE_IN = 1'h1, se;
	logic [11:0] PADDR_IN = 12'h0;
	logic [31:0] PWDATA_IN = 32'h0, q;
	logic [3:0]  PSTRB_IN = 4'hF;
	logic [15:0] CONVERSION_RESULT_IN = 16'h0, COMPARE_THRESHOLD_IN = 16'h0064;
	logic [6:0]  ev = 7'h0;
	wire WINDOW_MATCH_IN = ev[0], CONVERSION_DONE_IN = ev[1], SCAN_DONE_IN = ev[2];
	wire TRANSFER_READ_IN = ev[3], BUS_CONFLICT_IN = ev[4];
	wire CONVERSION_START_IN = ev[5], COMPARISON_TEST_IN = ev[6];
	logic [31:0] PRDATA_OUT, MODULATOR_CONFIG_OUT, ANALOG_CONTROL_OUT;
	logic [4:0]  RESULT_BITS_OUT;
	logic [7:0]  MODULATOR_STEP_OUT;
	logic        PREADY_OUT, PSLVERR_OUT, IRQ_OUT;
	int          err_total = 0, n_compared = 0, cyc = 0;
	logic [11:0] ra [4] = '{MODCFG_OFFSET, ANACTRL_OFFSET, IFLAGS_OFFSET, IENABLE_OFFSET};
	logic [31:0] rv [4] = '{32'h0, 32'h70, 32'h0, 32'h0};

	sense_dm_config_and_irq_flags u_dut (
		.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
		.PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
		.PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT),
		.PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
		.READ_CLEAR_ENABLE_IN(READ_CLEAR_ENABLE_IN),
		.BUS_CONFLICT_IN(BUS_CONFLICT_IN),
		.CONVERSION_START_IN(CONVERSION_START_IN),
		.COMPARISON_TEST_IN(COMPARISON_TEST_IN),
		.CONVERSION_DONE_IN(CONVERSION_DONE_IN),
		.CONVERSION_RESULT_IN(CONVERSION_RESULT_IN),
		.SCAN_DONE_IN(SCAN_DONE_IN),
		.TRANSFER_REQUEST_ENABLE_IN(TRANSFER_REQUEST_ENABLE_IN),
		.TRANSFER_READ_IN(TRANSFER_READ_IN),
		.COMPARE_ENABLE_IN(COMPARE_ENABLE_IN),
		.AVERAGE_WINDOW_ENABLE_IN(AVERAGE_WINDOW_ENABLE_IN),
		.WINDOW_MATCH_IN(WINDOW_MATCH_IN),
		.COMPARE_POLARITY_IN(COMPARE_POLARITY_IN),
		.COMPARE_THRESHOLD_IN(COMPARE_THRESHOLD_IN),
		.MODULATOR_CONFIG_OUT(MODULATOR_CONFIG_OUT),
		.ANALOG_CONTROL_OUT(ANALOG_CONTROL_OUT),
		.RESULT_BITS_OUT(RESULT_BITS_OUT),
		.MODULATOR_STEP_OUT(MODULATOR_STEP_OUT),
		.IRQ_OUT(IRQ_OUT)
	);

	always #20 MCLK_IN = ~MCLK_IN;

	task summarize;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Generous ceiling: the whole sequence needs under a thousand cycles
	always @(posedge MCLK_IN) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			summarize();
		end
	end

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Request held until ready is sampled high, as the bus requires
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge MCLK_IN);
		{PSEL_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} <= {1'h1, w, a, d};
		@(posedge MCLK_IN);
		PENABLE_IN <= 1'h1;
		do @(posedge MCLK_IN); while (PREADY_OUT !== 1'h1);
		q = PRDATA_OUT;
		se = PSLVERR_OUT;
		{PSEL_IN, PENABLE_IN} <= 2'h0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk($sformatf("read %h", a), q, e);
	endtask

	task pulse(input logic [6:0] m, input int n);
		repeat (n) begin
			@(posedge MCLK_IN);
			ev <= m;
		end
		@(posedge MCLK_IN);
		ev <= 7'h0;
	endtask

	task obs(input logic s, input logic [31:0] e);
		repeat (2) @(negedge MCLK_IN);
		chk(s ? "irq" : "step", s ? 32'(IRQ_OUT) : 32'(MODULATOR_STEP_OUT), e);
		@(posedge MCLK_IN);
	endtask

	initial begin
		repeat (6) @(posedge MCLK_IN);
		RESET_IN <= 1'h0;
		for (int i = 0; i < 4; i++) rd(ra[i], rv[i]);
		wr(MODCFG_OFFSET, 32'h103F0FFF);
		rd(MODCFG_OFFSET, 32'h103F0FFF);
		wr(ANACTRL_OFFSET, 32'h00700770);
		rd(ANACTRL_OFFSET, 32'h00700770);
		repeat (2) @(negedge MCLK_IN);
		chk("analog copy", ANALOG_CONTROL_OUT, 32'h00700770);
		for (int i = 0; i < 4; i++) begin
			wr(MODCFG_OFFSET, 32'(i) << 20);
			repeat (2) @(negedge MCLK_IN);
			chk("result bits", 32'(RESULT_BITS_OUT), 32'h0A + 32'(2 * i));
			chk("config copy", MODULATOR_CONFIG_OUT, 32'(i) << 20);
		end
		wr(IFSET_OFFSET, 32'h1F);
		rd(IFLAGS_OFFSET, 32'h1F);
		rd(IFSET_OFFSET, 32'h0);
		wr(IFCLR_OFFSET, 32'h05);
		rd(IFLAGS_OFFSET, 32'h1A);
		wr(IFCLR_OFFSET, 32'h0);
		rd(IFLAGS_OFFSET, 32'h1A);
		wr(IFCLR_OFFSET, 32'h1F);
		for (int i = 0; i < 5; i++) if (i != 3) begin
			pulse(7'(1 << i), 1);
			rd(IFLAGS_OFFSET, 32'(1 << i));
			wr(IFCLR_OFFSET, 32'h1F);
		end
		TRANSFER_REQUEST_ENABLE_IN <= 1'h1;
		pulse(7'h02, 1);
		pulse(7'h02, 1);
		rd(IFLAGS_OFFSET, 32'h0A);
		wr(IFCLR_OFFSET, 32'h1F);
		pulse(7'h08, 1);
		pulse(7'h02, 1);
		pulse(7'h08, 1);
		pulse(7'h02, 1);
		rd(IFLAGS_OFFSET, 32'h02);
		wr(MODCFG_OFFSET, 32'h240);
		pulse(7'h20, 1);
		obs(1'h0, 32'h40);
		pulse(7'h40, 1);
		obs(1'h0, 32'h40);
		pulse(7'h40, 1);
		obs(1'h0, 32'h20);
		wr(MODCFG_OFFSET, 32'h040);
		pulse(7'h20, 1);
		pulse(7'h40, 63);
		obs(1'h0, 32'h40);
		pulse(7'h40, 1);
		obs(1'h0, 32'h20);
		wr(MODCFG_OFFSET, 32'h10000140);
		pulse(7'h40, 4);
		obs(1'h0, 32'h20);
		wr(IFCLR_OFFSET, 32'h1F);
		wr(IENABLE_OFFSET, 32'h00000004);
		rd(IENABLE_OFFSET, 32'h04);
		pulse(7'h04, 1);
		obs(1'h1, 32'h1);
		wr(IENABLE_OFFSET, 32'h0);
		obs(1'h1, 32'h0);
		wr(IENABLE_OFFSET, 32'h04);
		obs(1'h1, 32'h1);
		wr(IFCLR_OFFSET, 32'h04);
		obs(1'h1, 32'h0);
		{AVERAGE_WINDOW_ENABLE_IN, TRANSFER_REQUEST_ENABLE_IN} <= 2'h0;
		for (int i = 0; i < 4; i++) begin
			wr(IFCLR_OFFSET, 32'h1F);
			CONVERSION_RESULT_IN <= 16'h0064 + 16'(i % 2);
			COMPARE_POLARITY_IN <= 1'(i / 2);
			pulse(7'h02, 1);
			rd(IFLAGS_OFFSET, 32'h2 + 32'(i == 0 || i == 3));
		end
		READ_CLEAR_ENABLE_IN <= 1'h1;
		wr(IFSET_OFFSET, 32'h11);
		rd(IFCLR_OFFSET, 32'h13);
		rd(IFLAGS_OFFSET, 32'h0);
		READ_CLEAR_ENABLE_IN <= 1'h0;
		ev <= 7'h04;
		wr(IFCLR_OFFSET, 32'h04);
		ev <= 7'h0;
		rd(IFLAGS_OFFSET, 32'h04);
		xfer(1'h0, 12'h0FC, 32'h0);
		chk("unmapped error", 32'(se), 32'h1);
		chk("unmapped data", q, 32'h0);
		RESET_IN <= 1'h1;
		repeat (2) @(posedge MCLK_IN);
		RESET_IN <= 1'h0;
		rd(IFLAGS_OFFSET, 32'h0);
		summarize();
	end
endmodule
`default_nettype wire
